// ### qsf_defines.svh
// Purpose: opcodes, field positions, reset values and timing for the flash command front end
// Assumes: included by bare name from the front-end module
// Notes: times in ns, clock rate in MHz
`ifndef QSF_DEFINES_SVH
`define QSF_DEFINES_SVH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define QSF_OP_NO_ACTION 8'h00
`define QSF_OP_RESET_ARM 8'h66
`define QSF_OP_RESET_GO 8'h99
`define QSF_OP_QUAD_ENTER 8'h38
`define QSF_OP_QUAD_EXIT 8'hFF
`define QSF_OP_RD_STAT 8'h05
`define QSF_OP_RD_CFG 8'h35
`define QSF_OP_WR_STAT 8'h01
`define QSF_OP_READ 8'h03
`define QSF_OP_FAST_READ 8'h0B
`define QSF_OP_QUAD_OUT_READ 8'h6B
`define QSF_OP_QUAD_IO_READ 8'hEB
`define QSF_OP_DUAL_OUT_READ 8'h3B
`define QSF_OP_DUAL_IO_READ 8'hBB
`define QSF_OP_SET_BURST 8'hC0
`define QSF_OP_QUAD_WRAP_READ 8'h0C
`define QSF_OP_SINGLE_WRAP_READ 8'hEC
`define QSF_OP_WRITE_ARM 8'h06
`define QSF_OP_WRITE_DISARM 8'h04
`define QSF_OP_SMALL_WIPE 8'h20
`define QSF_OP_LARGE_WIPE 8'hD8
`define QSF_OP_FULL_WIPE 8'hC7
`define QSF_OP_PAGE_WRITE 8'h02
`define QSF_OP_QUAD_PAGE_WRITE 8'h32
`define QSF_OP_PROT_MAP_WRITE 8'h42
`define QSF_OP_PROT_FREEZE 8'h8D
`define QSF_OP_PERM_LOCK_WRITE 8'hE8
`define QSF_OP_PROT_CLEAR_ALL 8'h98
`define QSF_OP_USER_ID_WRITE 8'hA5
`define QSF_OP_USER_ID_FREEZE 8'h85

// ----------------------------------------------------------------
// fields, limits, reset values, timing
// ----------------------------------------------------------------
`define QSF_STAT_BUSY_LO 0
`define QSF_STAT_ARM 1
`define QSF_STAT_PFRZ 4
`define QSF_STAT_IDLK 5
`define QSF_STAT_BUSY_HI 7
`define QSF_CFG_QPIN 1
`define QSF_CFG_VOLST 3
`define QSF_PROT_BYTES 9'd18
`define QSF_ID_BYTES 9'd256
`define QSF_BURST_RST 2'h0
`define QSF_CLK_MHZ 20
`define QSF_T_RCV_SHORT_NS 100000
`define QSF_T_RCV_LONG_NS 1000000

`endif

// ### qsf_pkg.sv
// Purpose: types shared by the flash command front end
// Assumes: qsf_defines.svh holds the numbers
// Notes: one-hot state codes
package qsf_pkg;

    typedef enum logic [5:0] {
        PH_IDLE = 6'b000001,
        PH_OP = 6'b000010,
        PH_ADR = 6'b000100,
        PH_DUM = 6'b001000,
        PH_DAT = 6'b010000,
        PH_SKIP = 6'b100000
    } qsf_phase_e;

    typedef enum logic [2:0] {
        DIR_NONE = 3'b001,
        DIR_IN = 3'b010,
        DIR_OUT = 3'b100
    } qsf_dir_e;

    typedef struct packed {
        logic ok;
        logic [1:0] nadr;
        logic [1:0] ndum;
        qsf_dir_e dir;
        logic [2:0] aw;
        logic [2:0] dw;
        logic wrap;
    } qsf_cmd_s;

endpackage

// ### qsf_front_end.sv
// Purpose: command front end of a serial/quad NOR flash, pin side to array side
// Assumes: sck and cs_n come from the host, sampled by clk (much faster than sck)
// Notes: array read data must be valid one clk after mem_addr changes
`include "qsf_defines.svh"

module qsf_front_end
    import qsf_pkg::*;
#(
    parameter int ADDR_W = 23,
    parameter int RCV_SHORT_CYC = `QSF_T_RCV_SHORT_NS * `QSF_CLK_MHZ / 1000,
    parameter int RCV_LONG_CYC = `QSF_T_RCV_LONG_NS * `QSF_CLK_MHZ / 1000
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // host pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic [3:0] sio_in,
    output logic [3:0] sio_out,
    output logic [3:0] sio_oe,
    // array side
    output logic [ADDR_W-1:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    input wire logic array_busy,
    output logic exec_pulse,
    output logic [7:0] exec_op,
    output logic [23:0] exec_addr,
    output logic abort_pulse,
    output logic soft_reset_pulse,
    output logic wd_pulse,
    output logic [7:0] wd_data,
    output logic [23:0] wd_addr,
    // state
    output logic write_arm_flag,
    output logic prot_freeze_flag,
    output logic id_lock_flag,
    output logic quad_pin_select,
    output logic four_wire_proto,
    output logic [1:0] burst_len_code,
    output logic recovering
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic cs_s1, cs_s2, cs_s3, ck_s1, ck_s2, ck_s3;
    logic [3:0] sio_s1, sio_s2;

    always_ff @(posedge clk) begin
        cs_s1 <= cs_n;
        cs_s2 <= cs_s1;
        cs_s3 <= cs_s2;
        ck_s1 <= sck;
        ck_s2 <= ck_s1;
        ck_s3 <= ck_s2;
        sio_s1 <= sio_in;
        sio_s2 <= sio_s1;
    end

    wire logic sck_rise = ck_s2 & ~ck_s3;
    wire logic sck_fall = ~ck_s2 & ck_s3;
    wire logic cs_rise = cs_s2 & ~cs_s3;

    // ----------------------------------------------------------------
    // opcode table
    // ----------------------------------------------------------------
    function automatic qsf_cmd_s decode(input logic [7:0] op, input logic q, input logic p);
        qsf_cmd_s c;
        c = '0;
        c.dir = DIR_NONE;
        c.aw = 3'd1;
        c.dw = 3'd1;
        case (op)
            `QSF_OP_NO_ACTION, `QSF_OP_RESET_ARM, `QSF_OP_RESET_GO, `QSF_OP_QUAD_EXIT,
            `QSF_OP_WRITE_ARM, `QSF_OP_WRITE_DISARM, `QSF_OP_FULL_WIPE,
            `QSF_OP_PROT_FREEZE, `QSF_OP_PROT_CLEAR_ALL, `QSF_OP_USER_ID_FREEZE: c.ok = 1'b1;
            `QSF_OP_QUAD_ENTER: c.ok = ~q;
            `QSF_OP_RD_STAT, `QSF_OP_RD_CFG: begin
                c.ok = 1'b1;
                c.ndum = {1'b0, q};
                c.dir = DIR_OUT;
            end
            `QSF_OP_WR_STAT, `QSF_OP_SET_BURST, `QSF_OP_PROT_MAP_WRITE,
            `QSF_OP_PERM_LOCK_WRITE: begin
                c.ok = 1'b1;
                c.dir = DIR_IN;
            end
            `QSF_OP_READ: begin
                c.ok = ~q;
                c.nadr = 2'd3;
                c.dir = DIR_OUT;
            end
            `QSF_OP_FAST_READ: begin
                c.ok = 1'b1;
                c.nadr = 2'd3;
                c.ndum = q ? 2'd3 : 2'd1;
                c.dir = DIR_OUT;
            end
            `QSF_OP_QUAD_OUT_READ: begin
                c.ok = ~q & p;
                c.nadr = 2'd3;
                c.ndum = 2'd1;
                c.dir = DIR_OUT;
                c.dw = 3'd4;
            end
            `QSF_OP_QUAD_IO_READ, `QSF_OP_SINGLE_WRAP_READ: begin
                c.ok = ~q & p;
                c.nadr = 2'd3;
                c.ndum = 2'd3;
                c.dir = DIR_OUT;
                c.aw = 3'd4;
                c.dw = 3'd4;
                c.wrap = (op == `QSF_OP_SINGLE_WRAP_READ);
            end
            `QSF_OP_DUAL_OUT_READ, `QSF_OP_DUAL_IO_READ: begin
                c.ok = ~q;
                c.nadr = 2'd3;
                c.ndum = 2'd1;
                c.dir = DIR_OUT;
                c.aw = (op == `QSF_OP_DUAL_IO_READ) ? 3'd2 : 3'd1;
                c.dw = 3'd2;
            end
            `QSF_OP_QUAD_WRAP_READ: begin
                c.ok = q;
                c.nadr = 2'd3;
                c.ndum = 2'd3;
                c.dir = DIR_OUT;
                c.wrap = 1'b1;
            end
            `QSF_OP_SMALL_WIPE, `QSF_OP_LARGE_WIPE: begin
                c.ok = 1'b1;
                c.nadr = 2'd3;
            end
            `QSF_OP_PAGE_WRITE, `QSF_OP_QUAD_PAGE_WRITE: begin
                c.ok = (op == `QSF_OP_PAGE_WRITE) | (~q & p);
                c.nadr = 2'd3;
                c.dir = DIR_IN;
                c.dw = (op == `QSF_OP_PAGE_WRITE) ? 3'd1 : 3'd4;
            end
            `QSF_OP_USER_ID_WRITE: begin
                c.ok = 1'b1;
                c.nadr = 2'd2;
                c.dir = DIR_IN;
            end
            default: c.ok = 1'b0;
        endcase
        if (q) begin
            c.aw = 3'd4;
            c.dw = 3'd4;
        end
        return c;
    endfunction

    // erase address masked to the block that holds it
    function automatic logic [23:0] blk_base(input logic [23:0] a);
        logic top, bot;
        top = &a[ADDR_W-1:16];
        bot = ~|a[ADDR_W-1:16];
        if ((bot & ~a[15]) | (top & a[15])) begin
            blk_base = {a[23:13], 13'h0000};
        end else if (top | bot) begin
            blk_base = {a[23:15], 15'h0000};
        end else begin
            blk_base = {a[23:16], 16'h0000};
        end
    endfunction

    // ----------------------------------------------------------------
    // command engine
    // ----------------------------------------------------------------
    qsf_phase_e phase_q, phase_d;
    qsf_cmd_s cmd_q, cmd_d, dec;
    logic [7:0] op_q, op_d, in_sr_q, in_sr_d, out_sr_q, out_sr_d, nxt_sr, ob, stat, cfg;
    logic [1:0] cnt_q, cnt_d, burst_q, burst_d, bpend_q, bpend_d;
    logic [8:0] dcnt_q, dcnt_d;
    logic [3:0] bcnt_q, bcnt_d, nxt_bc, ocnt_q, ocnt_d, sout_q, sout_d;
    logic [23:0] addr_q, addr_d, wmask;
    logic [15:0] rcv_q, rcv_d;
    logic [2:0] cur_w;
    logic done_q, done_d, arm_q, arm_d, wel_q, wel_d, pfrz_q, pfrz_d;
    logic idlk_q, idlk_d, qpin_q, qpin_d, quad_q, quad_d, cpend_q, cpend_d;
    logic xp_q, xp_d, ab_q, ab_d, sr_q, sr_d, wp_q, wp_d, wr_ok;
    logic [7:0] xop_q, xop_d, wd_q, wd_d;
    logic [23:0] xad_q, xad_d, wa_q, wa_d;

    assign cur_w = (phase_q == PH_OP) ? (quad_q ? 3'd4 : 3'd1) :
                   (phase_q == PH_DAT) ? cmd_q.dw : cmd_q.aw;
    assign nxt_sr = (cur_w == 3'd4) ? {in_sr_q[3:0], sio_s2} :
                    (cur_w == 3'd2) ? {in_sr_q[5:0], sio_s2[1:0]} : {in_sr_q[6:0], sio_s2[0]};
    assign nxt_bc = bcnt_q + {1'b0, cur_w};
    assign dec = decode(nxt_sr, quad_q, qpin_q);
    assign wr_ok = wel_q & ~array_busy;
    assign wmask = cmd_q.wrap ? 24'((9'h008 << burst_q) - 9'h001) : 24'hFFFFFF;

    always_comb begin
        stat = 8'h00;
        stat[`QSF_STAT_BUSY_LO] = array_busy;
        stat[`QSF_STAT_BUSY_HI] = array_busy;
        stat[`QSF_STAT_ARM] = wel_q;
        stat[`QSF_STAT_PFRZ] = pfrz_q;
        stat[`QSF_STAT_IDLK] = idlk_q;
        cfg = 8'h00;
        cfg[`QSF_CFG_QPIN] = qpin_q;
        cfg[`QSF_CFG_VOLST] = 1'b1;
    end

    always_comb begin
        phase_d = phase_q;
        cmd_d = cmd_q;
        op_d = op_q;
        in_sr_d = in_sr_q;
        out_sr_d = out_sr_q;
        cnt_d = cnt_q;
        dcnt_d = dcnt_q;
        bcnt_d = bcnt_q;
        ocnt_d = ocnt_q;
        sout_d = sout_q;
        addr_d = addr_q;
        done_d = done_q;
        arm_d = arm_q;
        wel_d = wel_q;
        pfrz_d = pfrz_q;
        idlk_d = idlk_q;
        qpin_d = qpin_q;
        quad_d = quad_q;
        burst_d = burst_q;
        bpend_d = bpend_q;
        cpend_d = cpend_q;
        rcv_d = (rcv_q != 16'h0000) ? rcv_q - 16'h0001 : rcv_q;
        xp_d = 1'b0;
        xop_d = xop_q;
        xad_d = xad_q;
        ab_d = 1'b0;
        sr_d = 1'b0;
        wp_d = 1'b0;
        wd_d = wd_q;
        wa_d = wa_q;
        ob = (ocnt_q == 4'h0) ? ((op_q == `QSF_OP_RD_STAT) ? stat :
             (op_q == `QSF_OP_RD_CFG) ? cfg : mem_rdata) : out_sr_q;
        if (cs_s2) begin
            phase_d = PH_IDLE;
            if (cs_rise && done_q) begin
                xop_d = op_q;
                xad_d = addr_q;
                arm_d = (op_q == `QSF_OP_RESET_ARM);
                case (op_q)
                    `QSF_OP_RESET_GO: if (arm_q) begin
                        quad_d = 1'b0;
                        burst_d = `QSF_BURST_RST;
                        wel_d = 1'b0;
                        qpin_d = 1'b0;
                        sr_d = 1'b1;
                        ab_d = array_busy;
                        rcv_d = array_busy ? 16'(RCV_LONG_CYC) : 16'(RCV_SHORT_CYC);
                    end
                    `QSF_OP_QUAD_ENTER: quad_d = 1'b1;
                    `QSF_OP_QUAD_EXIT: quad_d = 1'b0;
                    `QSF_OP_WRITE_ARM: wel_d = 1'b1;
                    `QSF_OP_WRITE_DISARM: wel_d = 1'b0;
                    `QSF_OP_SET_BURST: burst_d = bpend_q;
                    `QSF_OP_WR_STAT: if (wel_q) begin
                        qpin_d = cpend_q;
                        wel_d = 1'b0;
                    end
                    `QSF_OP_PROT_FREEZE: if (wr_ok) begin
                        pfrz_d = 1'b1;
                        wel_d = 1'b0;
                    end
                    `QSF_OP_USER_ID_FREEZE: if (wr_ok) begin
                        idlk_d = 1'b1;
                        wel_d = 1'b0;
                        xp_d = 1'b1;
                    end
                    `QSF_OP_PROT_CLEAR_ALL: xp_d = ~pfrz_q;
                    `QSF_OP_SMALL_WIPE, `QSF_OP_LARGE_WIPE, `QSF_OP_FULL_WIPE,
                    `QSF_OP_PAGE_WRITE, `QSF_OP_QUAD_PAGE_WRITE, `QSF_OP_USER_ID_WRITE,
                    `QSF_OP_PROT_MAP_WRITE, `QSF_OP_PERM_LOCK_WRITE: if (wr_ok) begin
                        xp_d = 1'b1;
                        wel_d = 1'b0;
                        if (op_q == `QSF_OP_SMALL_WIPE) begin
                            xad_d = {addr_q[23:12], 12'h000};
                        end else if (op_q == `QSF_OP_LARGE_WIPE) begin
                            xad_d = blk_base(addr_q);
                        end
                    end
                    default: ;
                endcase
            end
        end else if (phase_q == PH_IDLE) begin
            phase_d = (rcv_q != 16'h0000) ? PH_SKIP : PH_OP;
            bcnt_d = 4'h0;
            ocnt_d = 4'h0;
            dcnt_d = 9'h000;
            done_d = 1'b0;
        end else if (phase_q == PH_DAT && cmd_q.dir == DIR_OUT) begin
            if (sck_fall) begin
                sout_d = (cmd_q.dw == 3'd4) ? ob[7:4] :
                         (cmd_q.dw == 3'd2) ? {2'b00, ob[7:6]} : {2'b00, ob[7], 1'b0};
                out_sr_d = 8'(ob << cmd_q.dw);
                ocnt_d = ((ocnt_q == 4'h0) ? 4'h8 : ocnt_q) - {1'b0, cmd_q.dw};
                if (ocnt_q == 4'h0 && op_q != `QSF_OP_RD_STAT && op_q != `QSF_OP_RD_CFG) begin
                    addr_d = (addr_q & ~wmask) | ((addr_q + 24'h000001) & wmask);
                end
            end
        end else if (sck_rise && phase_q != PH_SKIP) begin
            in_sr_d = nxt_sr;
            bcnt_d = nxt_bc[3] ? 4'h0 : nxt_bc;
            if (nxt_bc[3]) begin
                unique case (phase_q)
                    PH_OP: begin
                        op_d = nxt_sr;
                        cmd_d = dec;
                        cnt_d = (dec.nadr != 2'd0) ? dec.nadr : dec.ndum;
                        if (nxt_sr != `QSF_OP_RESET_GO) arm_d = 1'b0;
                        if (!dec.ok) phase_d = PH_SKIP;
                        else if (dec.nadr != 2'd0) phase_d = PH_ADR;
                        else if (dec.ndum != 2'd0) phase_d = PH_DUM;
                        else phase_d = PH_DAT;
                        done_d = dec.ok & dec.nadr == 2'd0 & dec.dir == DIR_NONE;
                    end
                    PH_ADR: begin
                        addr_d = {addr_q[15:0], nxt_sr};
                        cnt_d = cnt_q - 2'd1;
                        if (cnt_q == 2'd1) begin
                            cnt_d = cmd_q.ndum;
                            phase_d = (cmd_q.ndum != 2'd0) ? PH_DUM : PH_DAT;
                            done_d = (cmd_q.dir == DIR_NONE);
                            if (op_q == `QSF_OP_USER_ID_WRITE) addr_d = {8'h00, addr_q[7:0], nxt_sr};
                        end
                    end
                    PH_DUM: begin
                        cnt_d = cnt_q - 2'd1;
                        if (cnt_q == 2'd1) phase_d = PH_DAT;
                    end
                    PH_DAT: begin
                        dcnt_d = (dcnt_q == 9'h1FF) ? dcnt_q : dcnt_q + 9'h001;
                        done_d = (op_q != `QSF_OP_WR_STAT) | (dcnt_q != 9'h000);
                        wd_d = nxt_sr;
                        wa_d = addr_q;
                        if (op_q == `QSF_OP_SET_BURST && dcnt_q == 9'h000) bpend_d = nxt_sr[1:0];
                        if (op_q == `QSF_OP_WR_STAT && dcnt_q == 9'h001) cpend_d = nxt_sr[1];
                        if (op_q == `QSF_OP_PAGE_WRITE || op_q == `QSF_OP_QUAD_PAGE_WRITE ||
                            op_q == `QSF_OP_USER_ID_WRITE) begin
                            wp_d = wr_ok & (dcnt_q < `QSF_ID_BYTES) &
                                   ~(idlk_q & op_q == `QSF_OP_USER_ID_WRITE);
                            addr_d = {addr_q[23:8], addr_q[7:0] + 8'h01};
                        end
                        if (op_q == `QSF_OP_PROT_MAP_WRITE || op_q == `QSF_OP_PERM_LOCK_WRITE) begin
                            wp_d = wr_ok & ~pfrz_q & (dcnt_q < `QSF_PROT_BYTES);
                            wa_d = {15'h0000, dcnt_q};
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            phase_q <= PH_IDLE;
            cmd_q <= '0;
            op_q <= 8'h00;
            in_sr_q <= 8'h00;
            out_sr_q <= 8'h00;
            cnt_q <= 2'h0;
            dcnt_q <= 9'h000;
            bcnt_q <= 4'h0;
            ocnt_q <= 4'h0;
            sout_q <= 4'h0;
            addr_q <= 24'h000000;
            done_q <= 1'b0;
            arm_q <= 1'b0;
            wel_q <= 1'b0;
            pfrz_q <= 1'b0;
            idlk_q <= 1'b0;
            qpin_q <= 1'b0;
            quad_q <= 1'b0;
            burst_q <= `QSF_BURST_RST;
            bpend_q <= `QSF_BURST_RST;
            cpend_q <= 1'b0;
            rcv_q <= 16'h0000;
            xp_q <= 1'b0;
            xop_q <= 8'h00;
            xad_q <= 24'h000000;
            ab_q <= 1'b0;
            sr_q <= 1'b0;
            wp_q <= 1'b0;
            wd_q <= 8'h00;
            wa_q <= 24'h000000;
        end else begin
            phase_q <= phase_d;
            cmd_q <= cmd_d;
            op_q <= op_d;
            in_sr_q <= in_sr_d;
            out_sr_q <= out_sr_d;
            cnt_q <= cnt_d;
            dcnt_q <= dcnt_d;
            bcnt_q <= bcnt_d;
            ocnt_q <= ocnt_d;
            sout_q <= sout_d;
            addr_q <= addr_d;
            done_q <= done_d;
            arm_q <= arm_d;
            wel_q <= wel_d;
            pfrz_q <= pfrz_d;
            idlk_q <= idlk_d;
            qpin_q <= qpin_d;
            quad_q <= quad_d;
            burst_q <= burst_d;
            bpend_q <= bpend_d;
            cpend_q <= cpend_d;
            rcv_q <= rcv_d;
            xp_q <= xp_d;
            xop_q <= xop_d;
            xad_q <= xad_d;
            ab_q <= ab_d;
            sr_q <= sr_d;
            wp_q <= wp_d;
            wd_q <= wd_d;
            wa_q <= wa_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    wire logic drv = ~cs_s2 & (phase_q == PH_DAT) & (cmd_q.dir == DIR_OUT);
    assign sio_oe = !drv ? 4'h0 : (cmd_q.dw == 3'd4) ? 4'hF : (cmd_q.dw == 3'd2) ? 4'h3 : 4'h2;
    assign sio_out = sout_q;
    assign mem_addr = addr_q[ADDR_W-1:0];
    assign exec_pulse = xp_q;
    assign exec_op = xop_q;
    assign exec_addr = xad_q;
    assign abort_pulse = ab_q;
    assign soft_reset_pulse = sr_q;
    assign wd_pulse = wp_q;
    assign wd_data = wd_q;
    assign wd_addr = wa_q;
    assign write_arm_flag = wel_q;
    assign prot_freeze_flag = pfrz_q;
    assign id_lock_flag = idlk_q;
    assign quad_pin_select = qpin_q;
    assign four_wire_proto = quad_q;
    assign burst_len_code = burst_q;
    assign recovering = (rcv_q != 16'h0000);

endmodule // qsf_front_end

// ### qsf_front_end_checker.sv
// Purpose: port assertions for the flash command front end
// Assumes: bound into qsf_front_end, single clock domain
// Notes: none
module qsf_front_end_checker (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // host pins
    input wire logic cs_n,
    input wire logic [3:0] sio_oe,
    // execution and state
    input wire logic exec_pulse,
    input wire logic [7:0] exec_op,
    input wire logic [23:0] exec_addr,
    input wire logic abort_pulse,
    input wire logic soft_reset_pulse,
    input wire logic write_arm_flag,
    input wire logic quad_pin_select,
    input wire logic four_wire_proto,
    input wire logic [1:0] burst_len_code,
    input wire logic recovering
);
    // ----------------
    // port checks
    // ----------------
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    property p_exec; exec_pulse |-> $past(cs_n, 2); endproperty
    a_exec: assert property (p_exec) else $error("exec in frame");
    property p_wipe; exec_pulse && exec_op == 8'h20 |-> exec_addr[11:0] == 12'h000; endproperty
    a_wipe: assert property (p_wipe) else $error("wipe addr");
    property p_arm; exec_pulse && exec_op == 8'h20 |-> $past(write_arm_flag); endproperty
    a_arm: assert property (p_arm) else $error("wipe unarmed");
    property p_rst; soft_reset_pulse |-> ##[0:1] !four_wire_proto && !quad_pin_select
        && !write_arm_flag && burst_len_code == 2'h0; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_rcv; soft_reset_pulse |-> ##[0:1] recovering [*8]; endproperty
    a_rcv: assert property (p_rcv) else $error("no recovery");
    property p_abort; abort_pulse |-> ##[0:1] recovering; endproperty
    a_abort: assert property (p_abort) else $error("abort");
    property p_idle; cs_n [*6] |-> sio_oe == 4'h0; endproperty
    a_idle: assert property (p_idle) else $error("pins driven");
    property p_proto; $changed(four_wire_proto) |-> $past(cs_n, 2); endproperty
    a_proto: assert property (p_proto) else $error("proto in frame");
endmodule // qsf_front_end_checker
bind qsf_front_end qsf_front_end_checker chk_u (.*);

// ### qsf_host_model.sv
// Purpose: host controller model driving framed commands
// Assumes: idle clock low, 400 ns serial period
// Notes: returns one byte from sio_out[1] per byte sent
module qsf_host_model (
    // clock
    input wire logic clk,
    // link
    output logic cs_n,
    output logic sck,
    output logic [3:0] sio_in,
    input wire logic [3:0] sio_out,
    input wire logic [3:0] sio_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        sio_in = 4'h0;
    end
    // half serial period, 2.5 MHz
    task automatic hp();
        repeat (4) @(posedge clk);
        #1;
    endtask
    // one frame per call, select held low throughout
    task automatic frame(input logic [7:0] b[$], input logic q, output logic [7:0] r[$]);
        logic [7:0] v;
        r = {};
        cs_n = 1'b0;
        hp();
        foreach (b[k]) begin
            for (int i = (q ? 1 : 7); i >= 0; i--) begin
                sck = 1'b0;
                sio_in = q ? b[k][i*4+:4] : {3'h0, b[k][i]};
                hp();
                sck = 1'b1;
                // released line floats to its pull-up level
                v = {v[6:0], sio_oe[1] ? sio_out[1] : 1'b1};
                hp();
            end
            r.push_back(v);
        end
        sck = 1'b0;
        hp();
        cs_n = 1'b1;
        repeat (4) hp();
    endtask
endmodule // qsf_host_model

// ### qsf_front_end_tb.sv
// Purpose: self-checking bench for the flash command front end
// Assumes: short recovery counts
// Notes: array data is address xor 5A
module qsf_front_end_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, cs_n, sck, array_busy, exec_pulse, abort_pulse, soft_reset_pulse;
    logic wd_pulse, write_arm_flag, prot_freeze_flag, id_lock_flag, quad_pin_select;
    logic four_wire_proto, recovering;
    logic [3:0] sio_in, sio_out, sio_oe;
    logic [22:0] mem_addr;
    logic [7:0] mem_rdata, exec_op, wd_data, r[$];
    logic [23:0] exec_addr, wd_addr;
    logic [1:0] burst_len_code;
    int n_mismatch, n_tests, n_cyc, n_rst, n_exec, n_wd;
    assign mem_rdata = mem_addr[7:0] ^ 8'h5A;
    qsf_front_end #(.RCV_SHORT_CYC(20), .RCV_LONG_CYC(50)) dut_u (.*);
    qsf_host_model host_u (.*);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        n_cyc++;
        n_rst += (soft_reset_pulse === 1'b1);
        n_exec += (exec_pulse === 1'b1);
        n_wd += (wd_pulse === 1'b1);
        if (n_cyc == 60000) begin
            n_mismatch++;
            test_done();
        end
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic t_read();
        host_u.frame({8'h03, 8'h7F, 8'hFF, 8'hFF, 8'h00, 8'h00}, 1'b0, r);
        chk(r[4], 8'hA5);
        chk(r[5], 8'h5A);
    endtask
    task automatic t_wipe();
        chk(write_arm_flag, 0);
        chk(quad_pin_select, 0);
        host_u.frame({8'h20, 8'h12, 8'h34, 8'h56}, 1'b0, r);
        host_u.frame({8'h06}, 1'b0, r);
        chk(write_arm_flag, 1);
        host_u.frame({8'h20, 8'h12, 8'h34}, 1'b0, r);
        chk(n_exec, 0);
        host_u.frame({8'h06}, 1'b0, r);
        host_u.frame({8'h20, 8'h12, 8'h34, 8'h56}, 1'b0, r);
        chk(n_exec, 1);
        chk(exec_addr, 24'h123000);
        chk(write_arm_flag, 0);
    endtask
    task automatic t_wr();
        host_u.frame({8'h06}, 1'b0, r);
        host_u.frame({8'h32, 8'h00, 8'h00, 8'h00, 8'hAB}, 1'b0, r);
        chk(write_arm_flag, 1'b1);
        host_u.frame({8'hD8, 8'h7F, 8'hA3, 8'h45}, 1'b0, r);
        chk(exec_addr, 24'h7FA000);
        host_u.frame({8'h06}, 1'b0, r);
        host_u.frame({8'hD8, 8'h12, 8'h34, 8'h56}, 1'b0, r);
        chk(exec_addr, 24'h120000);
        host_u.frame({8'h06}, 1'b0, r);
        host_u.frame({8'h42, 8'h11, 8'h22}, 1'b0, r);
        chk(n_wd, 2);
        chk(wd_addr, 24'h000001);
        chk(wd_data, 8'h22);
        host_u.frame({8'h06}, 1'b0, r);
        host_u.frame({8'h01, 8'h00, 8'h02}, 1'b0, r);
        chk(quad_pin_select, 1'b1);
        chk(n_exec, 4);
    endtask
    task automatic t_rst();
        host_u.frame({8'h99}, 1'b0, r);
        host_u.frame({8'h66}, 1'b0, r);
        host_u.frame({8'h00}, 1'b0, r);
        host_u.frame({8'h99}, 1'b0, r);
        chk(n_rst, 0);
        host_u.frame({8'h38}, 1'b0, r);
        chk(four_wire_proto, 1);
        host_u.frame({8'h66}, 1'b1, r);
        array_busy = 1'b1;
        host_u.frame({8'h99}, 1'b1, r);
        array_busy = 1'b0;
        chk(n_rst, 1);
        chk(four_wire_proto, 0);
        chk(quad_pin_select, 1'b0);
        chk(recovering, 1'b1);
        repeat (60) @(posedge clk);
        #1;
        host_u.frame({8'h38}, 1'b0, r);
        host_u.frame({8'hFF}, 1'b1, r);
        chk(four_wire_proto, 0);
    endtask
    initial begin
        nrst = 1'b0;
        array_busy = 1'b0;
        repeat (10) @(posedge clk);
        #1 nrst = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        t_read();
        t_wipe();
        t_wr();
        t_rst();
        test_done();
    end
endmodule // qsf_front_end_tb
